// ### intf_desc_source.sv
// streams the interface descriptor inside configuration descriptor data
`timescale 1ns/10ps
// What this block does
// [R1] Byte 0 carries descriptor length, nine; each field is one byte.
// [R2] Byte 1 carries the interface descriptor type code.
// [R3] Byte 2 carries the zero-based interface number.
// [R4] Byte 3 carries the alternate setting value.
// [R5] Byte 4 counts endpoints, excluding the default control pipe.
// [R6] Byte 5 carries class code; zero reserved, FFH vendor-specific.
// [R7] Byte 6 carries subclass, forced zero when class is zero.
// [R8] Subclass passes through unchanged under any nonzero class, not only FFH.
// [R9] Byte 7 carries protocol; zero means no class protocol.
// [R10] Protocol FFH means vendor-specific protocol.
// [R11] Byte 8 carries the interface string descriptor index.
// [R12] Served only inside configuration data, never standalone.
// [R13] Endpoint descriptors follow this descriptor immediately.
// [R14] Alternate setting zero is the default setting.
// [R15] Bytes leave in ascending order; host may cut the output short.
module intf_desc_source (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic in_config_data,
    input wire logic [15:0] byte_budget,
    input wire logic byte_ready,
    input wire logic [7:0] intf_number,
    input wire logic [7:0] alt_setting,
    input wire logic [7:0] num_endpoints,
    input wire logic [7:0] intf_class,
    input wire logic [7:0] intf_subclass,
    input wire logic [7:0] intf_protocol,
    input wire logic [7:0] string_index,
    input wire logic ep_done,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic byte_last,
    output logic ep_start,
    output logic busy,
    output logic is_default_alt
);
    // field values frozen when a transfer is taken, so a host that
    // stalls mid-stream never sees bytes from two different settings
    typedef struct packed {
        logic [7:0] number;
        logic [7:0] alt;
        logic [7:0] num_ep;
        logic [7:0] cls;
        logic [7:0] subcls;
        logic [7:0] proto;
        logic [7:0] str;
    } fields_type;

    typedef struct packed {
        intf_desc_pkg::phase_type phase;
        logic [3:0] offset;
        logic [15:0] budget;
        logic valid;
        logic [7:0] data;
        logic last;
        logic ep_go;
        fields_type fields;
    } state_type;

    state_type cur;
    state_type next_cur;
    fields_type live_fields;

    // lookup side
    logic [3:0] rom_offset;
    logic [7:0] rom_byte;

    // request acceptance
    logic take;
    logic first_last;
    logic [15:0] first_budget;

    // stream progress
    logic handshake;
    logic at_final;
    logic budget_spent;
    logic has_endpoints;
    logic [3:0] step_offset;
    logic [15:0] step_budget;
    logic step_last;

    // stream ending
    intf_desc_pkg::phase_type end_phase;
    logic end_pulse;

    // gather the live field inputs for capture
    always_comb begin
        live_fields.number = intf_number;
        live_fields.alt = alt_setting;
        live_fields.num_ep = num_endpoints;
        live_fields.cls = intf_class;
        live_fields.subcls = intf_subclass;
        live_fields.proto = intf_protocol;
        live_fields.str = string_index;
    end

    // a request counts only inside configuration data with bytes wanted
    always_comb begin
        take = 1'b0;
        if (start && in_config_data) begin // [R12]
            if (byte_budget != 16'h0000) begin
                take = 1'b1;
            end
        end
        first_budget = byte_budget - 16'h0001;
        first_last = (byte_budget == 16'h0001);
    end

    // where the stream stands once the byte on offer is taken
    always_comb begin
        handshake = cur.valid && byte_ready;
        at_final = (cur.offset == intf_desc_pkg::off_last);
        budget_spent = (cur.budget == 16'h0000);
        has_endpoints = (cur.fields.num_ep != 8'h00);
        step_offset = cur.offset + 4'h1;
        step_budget = cur.budget - 16'h0001;
        step_last = 1'b0;
        if (step_offset == intf_desc_pkg::off_last) begin
            step_last = 1'b1;
        end
        if (cur.budget == 16'h0001) begin
            step_last = 1'b1;
        end
    end

    // a cut-short stream has no room for endpoint descriptors
    always_comb begin
        end_phase = intf_desc_pkg::st_idle; // [R15]
        end_pulse = 1'b0;
        if (at_final && has_endpoints && !budget_spent) begin
            end_phase = intf_desc_pkg::st_ep; // [R13]
            end_pulse = 1'b1;
        end
    end

    // the lookup works one byte ahead of the registered output
    always_comb begin
        case (cur.phase)
            intf_desc_pkg::st_send: rom_offset = step_offset;
            default: rom_offset = intf_desc_pkg::off_length; // [R15]
        endcase
    end

    intf_desc_rom rom (
        .offset(rom_offset),
        .intf_number(cur.fields.number),
        .alt_setting(cur.fields.alt),
        .num_endpoints(cur.fields.num_ep),
        .intf_class(cur.fields.cls),
        .intf_subclass(cur.fields.subcls),
        .intf_protocol(cur.fields.proto),
        .string_index(cur.fields.str),
        .byte_value(rom_byte)
    );

    // one step of the byte stream
    always_comb begin
        next_cur = cur;
        next_cur.ep_go = 1'b0;
        case (cur.phase)
            intf_desc_pkg::st_idle: begin
                next_cur.valid = 1'b0;
                next_cur.last = 1'b0;
                if (take) begin
                    next_cur.phase = intf_desc_pkg::st_send;
                    next_cur.offset = intf_desc_pkg::off_length; // [R15]
                    next_cur.budget = first_budget;
                    next_cur.valid = 1'b1;
                    next_cur.data = rom_byte;
                    next_cur.last = first_last;
                    next_cur.fields = live_fields;
                end
            end
            intf_desc_pkg::st_send: begin
                if (handshake && cur.last) begin
                    next_cur.phase = end_phase;
                    next_cur.valid = 1'b0;
                    next_cur.last = 1'b0;
                    next_cur.ep_go = end_pulse; // [R13]
                end else if (handshake) begin
                    next_cur.offset = step_offset; // [R15]
                    next_cur.budget = step_budget;
                    next_cur.data = rom_byte;
                    next_cur.last = step_last;
                end else begin
                    // host stalled: the byte on offer stays put
                    next_cur.data = cur.data;
                end
            end
            intf_desc_pkg::st_ep: begin
                // partner now sends the endpoint descriptors
                if (ep_done) begin
                    next_cur.phase = intf_desc_pkg::st_idle;
                end
            end
            default: begin
                next_cur.phase = intf_desc_pkg::st_idle;
                next_cur.valid = 1'b0;
            end
        endcase
    end

    // synchronous reset returns to idle with every output low except is_default_alt, which follows alt_setting
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign byte_valid = cur.valid;
    assign byte_data = cur.data;
    assign byte_last = cur.last;
    assign ep_start = cur.ep_go;
    assign busy = (cur.phase != intf_desc_pkg::st_idle);
    assign is_default_alt = (alt_setting == intf_desc_pkg::alt_default); // [R14]
endmodule

// ### intf_desc_pkg.sv
// constants for the interface descriptor byte source
package intf_desc_pkg;
    localparam logic [7:0] desc_length = 8'h09;
    localparam logic [7:0] desc_type_interface = 8'h04;
    localparam logic [3:0] off_length = 4'h0;
    localparam logic [3:0] off_type = 4'h1;
    localparam logic [3:0] off_number = 4'h2;
    localparam logic [3:0] off_alt = 4'h3;
    localparam logic [3:0] off_num_ep = 4'h4;
    localparam logic [3:0] off_class = 4'h5;
    localparam logic [3:0] off_subclass = 4'h6;
    localparam logic [3:0] off_protocol = 4'h7;
    localparam logic [3:0] off_string = 4'h8;
    localparam logic [3:0] off_last = 4'h8;
    localparam logic [7:0] class_reserved = 8'h00;
    localparam logic [7:0] class_vendor = 8'hFF;
    localparam logic [7:0] protocol_none = 8'h00;
    localparam logic [7:0] protocol_vendor = 8'hFF;
    localparam logic [7:0] alt_default = 8'h00;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_send = 2'b01,
        st_ep = 2'b10
    } phase_type;
endpackage

// ### intf_desc_rom.sv
// combinational byte lookup of the nine-byte interface descriptor
`timescale 1ns/10ps
module intf_desc_rom (
    input wire logic [3:0] offset,
    input wire logic [7:0] intf_number,
    input wire logic [7:0] alt_setting,
    input wire logic [7:0] num_endpoints,
    input wire logic [7:0] intf_class,
    input wire logic [7:0] intf_subclass,
    input wire logic [7:0] intf_protocol,
    input wire logic [7:0] string_index,
    output logic [7:0] byte_value
);
    always_comb begin
        case (offset)
            intf_desc_pkg::off_length: byte_value = intf_desc_pkg::desc_length; // [R1]
            intf_desc_pkg::off_type: byte_value = intf_desc_pkg::desc_type_interface; // [R2]
            intf_desc_pkg::off_number: byte_value = intf_number; // [R3]
            intf_desc_pkg::off_alt: byte_value = alt_setting; // [R4]
            intf_desc_pkg::off_num_ep: byte_value = num_endpoints; // [R5]
            intf_desc_pkg::off_class: byte_value = intf_class; // [R6]
            intf_desc_pkg::off_subclass: begin
                if (intf_class == intf_desc_pkg::class_reserved) begin
                    byte_value = 8'h00; // [R7]
                end else begin
                    byte_value = intf_subclass; // [R8]
                end
            end
            intf_desc_pkg::off_protocol: byte_value = intf_protocol; // [R9] [R10]
            intf_desc_pkg::off_string: byte_value = string_index; // [R11]
            default: byte_value = 8'h00;
        endcase
    end
endmodule

// ### intf_desc_checker.sv
// port assertions for the interface descriptor byte source
`timescale 1ns/10ps
module intf_desc_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic byte_ready,
    input wire logic [7:0] intf_number,
    input wire logic [7:0] alt_setting,
    input wire logic [7:0] intf_class,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_last,
    input wire logic ep_start,
    input wire logic busy,
    input wire logic is_default_alt
);
    logic [3:0] off;
    always_ff @(posedge clk_sys) begin
        off <= (rst || !busy) ? 4'h0 : off + 4'(byte_valid && byte_ready);
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_len_byte:
        assert property (byte_valid && off == 4'h0 |-> byte_data == 8'h09) else $error("len");
    a_type_byte:
        assert property (byte_valid && off == 4'h1 |-> byte_data == 8'h04) else $error("type");
    a_number_byte:
        assert property (byte_valid && off == 4'h2 |-> byte_data == intf_number)
            else $error("num");
    a_class_byte:
        assert property (byte_valid && off == 4'h5 |-> byte_data == intf_class)
            else $error("class");
    a_sub_zero:
        assert property (byte_valid && off == 4'h6 && intf_class == 8'h00 |-> byte_data == 8'h00)
            else $error("sub");
    a_last_mark:
        assert property (byte_valid && off == 4'h8 |-> byte_last) else $error("last");
    a_hold_stall:
        assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
            else $error("hold");
    a_ep_after:
        assert property (ep_start |-> $past(byte_valid && byte_ready && byte_last))
            else $error("ep");
    a_last_ends:
        assert property (byte_valid && byte_ready && byte_last |=> !byte_valid)
            else $error("end");
    a_default_alt:
        assert property (is_default_alt == (alt_setting == 8'h00)) else $error("alt");
endmodule
bind intf_desc_source intf_desc_checker chk (.clk_sys, .rst, .byte_ready, .intf_number,
    .alt_setting, .intf_class, .byte_valid, .byte_data, .byte_last, .ep_start, .busy,
    .is_default_alt);

// ### intf_desc_host.sv
// host side consumer that collects descriptor bytes
`timescale 1ns/10ps
module intf_desc_host (
    input wire logic clk_sys,
    input wire logic clear,
    input wire logic stall,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic ep_start,
    output logic byte_ready = 1'b0,
    output logic ep_done = 1'b0
);
    logic [7:0] got[16];
    logic [7:0] n = 8'h00;
    logic [7:0] eps = 8'h00;
    // slow mode takes every other cycle
    always @(posedge clk_sys) begin
        byte_ready <= stall ? ~byte_ready : 1'b1;
        ep_done <= ep_start;
        if (clear) begin
            n <= 8'h00;
            eps <= 8'h00;
        end else begin
            if (byte_valid && byte_ready) begin
                got[n[3:0]] <= byte_data;
                n <= n + 8'h01;
            end
            if (ep_start) begin
                eps <= eps + 8'h01;
            end
        end
    end
endmodule

// ### tb.sv
// self-checking bench for the interface descriptor byte source
`timescale 1ns/10ps
module tb;
    logic clk_sys = 0, rst = 1, start = 0, in_config_data = 0, stall = 0, clear = 0;
    logic [15:0] byte_budget = 16'h0000;
    logic [7:0] intf_number = 8'h03, alt_setting = 8'h00, num_endpoints = 8'h02;
    logic [7:0] intf_class = 8'h00, intf_subclass = 8'h5A, intf_protocol = 8'h00;
    logic [7:0] string_index = 8'h07, byte_data;
    logic byte_ready, ep_done, byte_valid, byte_last, ep_start, busy, is_default_alt;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    intf_desc_source uut (.clk_sys, .rst, .start, .in_config_data, .byte_budget, .byte_ready,
        .intf_number, .alt_setting, .num_endpoints, .intf_class, .intf_subclass,
        .intf_protocol, .string_index, .ep_done, .byte_valid, .byte_data, .byte_last,
        .ep_start, .busy, .is_default_alt);
    intf_desc_host host (.clk_sys, .clear, .stall, .byte_valid, .byte_data, .ep_start,
        .byte_ready, .ep_done);
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            results;
        end
    end
    task results;
        if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input int i);
        logic [7:0] t[9];
        t = '{8'h09, 8'h04, intf_number, alt_setting, num_endpoints, intf_class,
            (intf_class == 8'h00) ? 8'h00 : intf_subclass, intf_protocol, string_index};
        return t[i];
    endfunction
    task xfer(input logic [15:0] b, input logic c, input logic [7:0] cnt);
        int i;
        @(posedge clk_sys);
        clear <= 1'b1;
        start <= 1'b1;
        byte_budget <= b;
        in_config_data <= c;
        @(posedge clk_sys);
        clear <= 1'b0;
        start <= 1'b0;
        // first look one edge later, once the taken request shows
        @(posedge clk_sys);
        i = 0;
        while ((busy === 1'b1 || byte_valid === 1'b1) && i < 200) begin
            @(posedge clk_sys);
            i++;
        end
        repeat (3) @(posedge clk_sys);
        chk(8'(busy), 8'h00);
        chk(host.n, cnt);
        for (i = 0; i < cnt; i++) begin
            chk(host.got[i], exp_byte(i));
        end
    endtask
    task t_masked;
        xfer(16'h0040, 1'b1, 8'h09);
        chk(host.eps, 8'h01);
        chk(8'(is_default_alt), 8'h01);
    endtask
    task t_vendor;
        stall <= 1'b1;
        intf_class <= 8'hFF;
        intf_protocol <= 8'hFF;
        num_endpoints <= 8'h00;
        alt_setting <= 8'h01;
        xfer(16'h0009, 1'b1, 8'h09);
        chk(host.eps, 8'h00);
        chk(8'(is_default_alt), 8'h00);
    endtask
    task t_refused;
        num_endpoints <= 8'h02;
        xfer(16'h0003, 1'b1, 8'h03);
        chk(host.eps, 8'h00);
        xfer(16'h0009, 1'b1, 8'h09);
        chk(host.eps, 8'h00);
        xfer(16'h0040, 1'b0, 8'h00);
        xfer(16'h0000, 1'b1, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_masked;
        t_vendor;
        t_refused;
        results;
    end
endmodule
